/* dihso_pkg.sv */
`default_nettype none
package dihso_pkg;

  // ******************************************************************
  // Register map
  // ******************************************************************
  // Register offsets are indices: the byte address on the bus is four
  // times the index.
  localparam logic [7:0] REG_PATTERN_INDIRECT_ADDRESS = 8'h66;
  localparam logic [7:0] REG_PATTERN_INDIRECT_DATA    = 8'h67;
  localparam logic [7:0] REG_SYNC_CTRL0               = 8'h6a;
  localparam logic [7:0] REG_SYNC_WIDTH_LOW           = 8'h6b;
  localparam logic [7:0] REG_BACK_PORCH_LOW           = 8'h6c;
  localparam logic [7:0] REG_PORT_SELECT              = 8'h70;
  localparam logic [7:0] REG_MODE                     = 8'h71;
  localparam logic [7:0] REG_MEASURED_SYNC_LOW        = 8'h72;
  localparam logic [7:0] REG_MEASURED_PORCH_LOW       = 8'h73;
  localparam logic [7:0] REG_MEASURED_HIGH            = 8'h74;

  localparam int ADDR_W     = 10;
  localparam int DATA_W     = 32;
  localparam int REG_W      = 8;
  localparam int TIMING_W   = 10;
  localparam int INDIRECT_AW = 8;

  // ******************************************************************
  // Control register 0 fields
  // ******************************************************************
  localparam int CTRL0_BACK_PORCH_EN  = 7;
  localparam int CTRL0_BACK_PORCH_HI  = 5;
  localparam int CTRL0_BACK_PORCH_LO  = 4;
  localparam int CTRL0_SYNC_WIDTH_EN  = 3;
  localparam int CTRL0_SYNC_WIDTH_HI  = 1;
  localparam int CTRL0_SYNC_WIDTH_LO  = 0;
  localparam logic [7:0] CTRL0_WRITE_MASK = 8'hbb;

  localparam int MODE_DUAL_IMAGE_BIT  = 0;
  localparam int MODE_INDEPENDENT_BIT = 1;
  localparam logic [7:0] MODE_WRITE_MASK = 8'h03;
  localparam logic [7:0] REG_RESET_VALUE = 8'h00;

  localparam logic [TIMING_W-1:0] COUNT_ONE = 10'h001;
  localparam logic [TIMING_W-1:0] COUNT_MAX = 10'h3ff;

endpackage : dihso_pkg
`default_nettype wire

/* dihso_port_timing.sv */
`default_nettype none
module dihso_port_timing
  import dihso_pkg::*;
#(
  parameter int W = TIMING_W
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         dual_image,
  input  wire logic         vid_hsync,
  input  wire logic         vid_de,
  input  wire logic         porch_en,
  input  wire logic         sync_en,
  input  wire logic [W-1:0] porch_ov,
  input  wire logic [W-1:0] sync_ov,
  output logic              out_hsync,
  output logic              out_de,
  output logic      [W-1:0] meas_sync,
  output logic      [W-1:0] meas_porch
);
  import dihso_pkg::*;

  // ******************************************************************
  // Measurement of the incoming line
  // ******************************************************************
  typedef enum logic [1:0] {
    DIHSO_IDLE  = 2'b00,
    DIHSO_SYNC  = 2'b01,
    DIHSO_PORCH = 2'b10,
    DIHSO_ACT   = 2'b11
  } dihso_gen_type;

  logic [W-1:0] cnt_q, cnt_d, msync_q, msync_d, mporch_q, mporch_d;
  logic         hs_q, hs_d;
  logic [W-1:0] gcnt_q, gcnt_d;
  dihso_gen_type gst_q, gst_d;
  logic         ohs_q, ohs_d, ode_q, ode_d;
  logic [W-1:0] use_sync, use_porch;

  // The measurement counter saturates so that a line with an over-long pulse reads as
  // the largest value instead of wrapping to a short one.
  always_comb begin
    hs_d     = vid_hsync;
    msync_d  = msync_q;
    mporch_d = mporch_q;
    cnt_d    = (cnt_q == COUNT_MAX) ? cnt_q : cnt_q + COUNT_ONE;
    if (vid_hsync && !hs_q) begin
      cnt_d = COUNT_ONE;
    end else if (!vid_hsync && hs_q) begin
      msync_d = cnt_q;
      cnt_d   = COUNT_ONE;
    end else if (vid_de && !vid_hsync && cnt_q != '0) begin
      mporch_d = cnt_q;
      cnt_d    = '0;
    end else if (cnt_q == '0) begin
      cnt_d = '0;
    end
  end

  // ******************************************************************
  // Regenerated sync and porch
  // ******************************************************************
  always_comb begin
    use_sync  = sync_en ? sync_ov : msync_q;
    use_porch = porch_en ? porch_ov : mporch_q;
  end

  always_comb begin
    gst_d  = gst_q;
    gcnt_d = gcnt_q + COUNT_ONE;
    ohs_d  = vid_hsync;
    ode_d  = vid_de;
    if (dual_image) begin
      ohs_d = 1'b0;
      ode_d = 1'b0;
      case (gst_q)
        DIHSO_IDLE: begin
          if (vid_hsync && !hs_q) begin
            gst_d  = DIHSO_SYNC;
            gcnt_d = COUNT_ONE;
            ohs_d  = 1'b1;
          end
        end
        DIHSO_SYNC: begin
          ohs_d = 1'b1;
          if (gcnt_q >= use_sync) begin
            gst_d  = DIHSO_PORCH;
            gcnt_d = COUNT_ONE;
            ohs_d  = 1'b0;
          end
        end
        DIHSO_PORCH: begin
          // Data enable opens on the last porch cycle so that the porch
          // lasts exactly the programmed or measured count.
          if (gcnt_q >= use_porch) begin
            gst_d = DIHSO_ACT;
            ode_d = vid_de;
          end
        end
        DIHSO_ACT: begin
          ode_d = vid_de;
          if (vid_hsync && !hs_q) begin
            gst_d  = DIHSO_SYNC;
            gcnt_d = COUNT_ONE;
            ohs_d  = 1'b1;
            ode_d  = 1'b0;
          end
        end
        default: gst_d = DIHSO_IDLE;
      endcase
    end else begin
      gst_d = DIHSO_IDLE;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q    <= '0;
      msync_q  <= '0;
      mporch_q <= '0;
      hs_q     <= 1'b0;
      gcnt_q   <= '0;
      gst_q    <= DIHSO_IDLE;
      ohs_q    <= 1'b0;
      ode_q    <= 1'b0;
    end else begin
      cnt_q    <= cnt_d;
      msync_q  <= msync_d;
      mporch_q <= mporch_d;
      hs_q     <= hs_d;
      gcnt_q   <= gcnt_d;
      gst_q    <= gst_d;
      ohs_q    <= ohs_d;
      ode_q    <= ode_d;
    end
  end

  assign out_hsync  = ohs_q;
  assign out_de     = ode_q;
  assign meas_sync  = msync_q;
  assign meas_porch = mporch_q;

endmodule : dihso_port_timing
`default_nettype wire

/* dihso_top.sv */
`default_nettype none
// Contract
// - Indirect data write stores the byte at the indirect address.
// - Indirect data read returns the addressed location's contents.
// - Independent mode: indirect access reaches only the selected port.
// - Dual-image mode measures input back porch and regenerates it.
// - Dual-image mode measures input sync width and regenerates it.
// - Porch override enable swaps measured porch for the programmed value.
// - Sync override enable swaps measured width for the programmed value.
// - Porch override: ten bits, ctrl0 bits 5-4 over porch low register.
// - Sync override: ten bits, ctrl0 bits 1-0 over width low register.
// - Override settings act on the selected port in independent mode, on every port otherwise; each port has a copy.
module dihso_top
  import dihso_pkg::*;
#(
  parameter int PORTS = 2
) (
  input  wire logic                     MCLK,
  input  wire logic                     RST,
  input  wire logic [dihso_pkg::ADDR_W-1:0] AVS_ADDRESS,
  input  wire logic                     AVS_READ,
  input  wire logic                     AVS_WRITE,
  input  wire logic [3:0]               AVS_BYTEENABLE,
  input  wire logic [dihso_pkg::DATA_W-1:0] AVS_WRITEDATA,
  output logic      [dihso_pkg::DATA_W-1:0] AVS_READDATA,
  output logic                          AVS_WAITREQUEST,
  input  wire logic [PORTS-1:0]         VID_HSYNC,
  input  wire logic [PORTS-1:0]         VID_DE,
  output logic      [PORTS-1:0]         OUT_HSYNC,
  output logic      [PORTS-1:0]         OUT_DE
);
  import dihso_pkg::*;

  localparam int PSEL_W = (PORTS > 1) ? $clog2(PORTS) : 1;
  localparam int MEM_D  = 1 << INDIRECT_AW;

  // ******************************************************************
  // Register storage, one copy per serial output port except port select and mode
  // ******************************************************************
  logic [REG_W-1:0] ia_q    [PORTS];
  logic [REG_W-1:0] ia_d    [PORTS];
  logic [REG_W-1:0] ctrl0_q [PORTS];
  logic [REG_W-1:0] ctrl0_d [PORTS];
  logic [REG_W-1:0] swl_q   [PORTS];
  logic [REG_W-1:0] swl_d   [PORTS];
  logic [REG_W-1:0] bpl_q   [PORTS];
  logic [REG_W-1:0] bpl_d   [PORTS];
  logic [REG_W-1:0] mem     [PORTS][MEM_D];
  logic [PSEL_W-1:0] psel_q, psel_d;
  logic [REG_W-1:0] mode_q, mode_d;
  logic             ack_q, ack_d;
  logic             wreq_q, wreq_d;
  logic [DATA_W-1:0] rd_q, rd_d;
  logic [TIMING_W-1:0] msync [PORTS];
  logic [TIMING_W-1:0] mporch [PORTS];
  logic [PORTS-1:0] ohs, ode;
  logic [PORTS-1:0] ohs_q, ode_q;

  logic [7:0] idx;
  logic       req, wr_lane;
  logic [REG_W-1:0] wb;
  logic [PSEL_W-1:0] ap;
  logic       dual, indep;

  assign idx     = AVS_ADDRESS[ADDR_W-1:2];
  assign req     = (AVS_READ || AVS_WRITE) && !ack_q;
  assign wr_lane = AVS_WRITE && !ack_q && AVS_BYTEENABLE[0];
  assign wb      = AVS_WRITEDATA[REG_W-1:0];
  assign dual    = mode_q[MODE_DUAL_IMAGE_BIT];
  assign indep   = mode_q[MODE_INDEPENDENT_BIT];
  // Without independent mode both ports share one programming: port 0's
  // copy is the one addressed and read back.
  assign ap      = indep ? psel_q : '0;

  // ******************************************************************
  // Bus slave: one wait cycle, then acknowledge
  // ******************************************************************
  always_comb begin
    ack_d  = req;
    wreq_d = !req;
    rd_d   = '0;
    psel_d = psel_q;
    mode_d = mode_q;
    for (int p = 0; p < PORTS; p++) begin
      ia_d[p]    = ia_q[p];
      ctrl0_d[p] = ctrl0_q[p];
      swl_d[p]   = swl_q[p];
      bpl_d[p]   = bpl_q[p];
    end
    if (wr_lane) begin
      for (int p = 0; p < PORTS; p++) begin
        if (!indep || ap == PSEL_W'(p)) begin
          case (idx)
            REG_PATTERN_INDIRECT_ADDRESS: ia_d[p] = wb;
            REG_SYNC_CTRL0: ctrl0_d[p] = wb & CTRL0_WRITE_MASK;
            REG_SYNC_WIDTH_LOW: swl_d[p] = wb;
            REG_BACK_PORCH_LOW: bpl_d[p] = wb;
            default: ;
          endcase
        end
      end
      case (idx)
        REG_PORT_SELECT: psel_d = wb[PSEL_W-1:0];
        REG_MODE: mode_d = wb & MODE_WRITE_MASK;
        default: ;
      endcase
    end
    if (AVS_READ && !ack_q) begin
      case (idx)
        REG_PATTERN_INDIRECT_ADDRESS: rd_d[REG_W-1:0] = ia_q[ap];
        REG_PATTERN_INDIRECT_DATA:
          rd_d[REG_W-1:0] = mem[ap][ia_q[ap]];
        REG_SYNC_CTRL0: rd_d[REG_W-1:0] = ctrl0_q[ap];
        REG_SYNC_WIDTH_LOW: rd_d[REG_W-1:0] = swl_q[ap];
        REG_BACK_PORCH_LOW: rd_d[REG_W-1:0] = bpl_q[ap];
        REG_PORT_SELECT: rd_d[PSEL_W-1:0] = psel_q;
        REG_MODE: rd_d[REG_W-1:0] = mode_q;
        REG_MEASURED_SYNC_LOW: rd_d[REG_W-1:0] = msync[ap][REG_W-1:0];
        REG_MEASURED_PORCH_LOW: rd_d[REG_W-1:0] = mporch[ap][REG_W-1:0];
        REG_MEASURED_HIGH: rd_d[REG_W-1:0] = {2'h0,
            mporch[ap][TIMING_W-1:REG_W], 2'h0, msync[ap][TIMING_W-1:REG_W]};
        default: rd_d = '0;
      endcase
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ack_q  <= 1'b0;
      wreq_q <= 1'b1;
      rd_q   <= '0;
      psel_q <= '0;
      mode_q <= REG_RESET_VALUE;
      for (int p = 0; p < PORTS; p++) begin
        ia_q[p]    <= REG_RESET_VALUE;
        ctrl0_q[p] <= REG_RESET_VALUE;
        swl_q[p]   <= REG_RESET_VALUE;
        bpl_q[p]   <= REG_RESET_VALUE;
      end
    end else begin
      ack_q  <= ack_d;
      wreq_q <= wreq_d;
      rd_q   <= rd_d;
      psel_q <= psel_d;
      mode_q <= mode_d;
      for (int p = 0; p < PORTS; p++) begin
        ia_q[p]    <= ia_d[p];
        ctrl0_q[p] <= ctrl0_d[p];
        swl_q[p]   <= swl_d[p];
        bpl_q[p]   <= bpl_d[p];
      end
    end
  end

  // ******************************************************************
  // Indirect pattern memory
  // ******************************************************************
  // Kept out of reset so it can map onto a RAM; contents are undefined
  // until software writes them.
  always_ff @(posedge MCLK) begin
    if (wr_lane && idx == REG_PATTERN_INDIRECT_DATA) begin
      for (int p = 0; p < PORTS; p++) begin
        if (!indep || ap == PSEL_W'(p)) begin
          mem[p][ia_q[p]] <= wb;
        end
      end
    end
  end

  // ******************************************************************
  // Per-port sync regeneration
  // ******************************************************************
  for (genvar g = 0; g < PORTS; g++) begin : g_port
    dihso_port_timing #(
      .W (TIMING_W)
    ) u_timing (
      .clk        (MCLK),
      .rst        (RST),
      .dual_image (dual),
      .vid_hsync  (VID_HSYNC[g]),
      .vid_de     (VID_DE[g]),
      .porch_en   (ctrl0_q[g][CTRL0_BACK_PORCH_EN]),
      .sync_en    (ctrl0_q[g][CTRL0_SYNC_WIDTH_EN]),
      .porch_ov   ({ctrl0_q[g][CTRL0_BACK_PORCH_HI:CTRL0_BACK_PORCH_LO],
                    bpl_q[g]}),
      .sync_ov    ({ctrl0_q[g][CTRL0_SYNC_WIDTH_HI:CTRL0_SYNC_WIDTH_LO],
                    swl_q[g]}),
      .out_hsync  (ohs[g]),
      .out_de     (ode[g]),
      .meas_sync  (msync[g]),
      .meas_porch (mporch[g])
    );
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ohs_q <= '0;
      ode_q <= '0;
    end else begin
      ohs_q <= ohs;
      ode_q <= ode;
    end
  end

  assign OUT_HSYNC       = ohs_q;
  assign OUT_DE          = ode_q;
  assign AVS_READDATA    = rd_q;
  assign AVS_WAITREQUEST = wreq_q;

endmodule : dihso_top
`default_nettype wire

/* dihso_props.sv */
`default_nettype none
module dihso_props
  import dihso_pkg::*;
#(
  parameter int PORTS = 2
) (
  input wire logic              MCLK,
  input wire logic              RST,
  input wire logic [dihso_pkg::ADDR_W-1:0] AVS_ADDRESS,
  input wire logic              AVS_READ,
  input wire logic              AVS_WRITE,
  input wire logic [3:0]        AVS_BYTEENABLE,
  input wire logic [dihso_pkg::DATA_W-1:0] AVS_WRITEDATA,
  input wire logic [dihso_pkg::DATA_W-1:0] AVS_READDATA,
  input wire logic              AVS_WAITREQUEST,
  input wire logic [PORTS-1:0]  VID_HSYNC,
  input wire logic [PORTS-1:0]  VID_DE,
  input wire logic [PORTS-1:0]  OUT_HSYNC,
  input wire logic [PORTS-1:0]  OUT_DE
);
  import dihso_pkg::*;
  logic       wr_ok;
  logic [7:0] idx;
  logic [7:0] mode_q, mode_d, c0_q, c0_d, lo_q, lo_d;
  logic [9:0] run_q, run_d, sync_exp;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  assign wr_ok = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0];
  assign idx = AVS_ADDRESS[9:2];
  // A zero override still ends the phase after one cycle.
  assign sync_exp = ({c0_q[1:0], lo_q} == 10'h000) ? 10'h001
                  : {c0_q[1:0], lo_q};
  // Shadows follow only shared writes; per-port writes are not tracked.
  always_comb begin
    mode_d = (wr_ok && idx == REG_MODE) ? AVS_WRITEDATA[7:0] : mode_q;
    c0_d = (wr_ok && !mode_q[1] && idx == REG_SYNC_CTRL0)
         ? AVS_WRITEDATA[7:0] : c0_q;
    lo_d = (wr_ok && !mode_q[1] && idx == REG_SYNC_WIDTH_LOW)
         ? AVS_WRITEDATA[7:0] : lo_q;
    run_d = OUT_HSYNC[0] ? run_q + 10'h001 : 10'h000;
  end
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      {mode_q, c0_q, lo_q, run_q} <= '0;
    end else begin
      {mode_q, c0_q, lo_q, run_q} <= {mode_d, c0_d, lo_d, run_d};
    end
  end
  property p_answer;
    $rose(AVS_READ || AVS_WRITE) |=> !AVS_WAITREQUEST;
  endproperty
  property p_once; !AVS_WAITREQUEST |=> AVS_WAITREQUEST; endproperty
  property p_cause; !AVS_WAITREQUEST |-> AVS_READ || AVS_WRITE; endproperty
  property p_upper;
    !AVS_WAITREQUEST && AVS_READ |-> AVS_READDATA[31:8] == 24'h0;
  endproperty
  property p_c0_read;
    !AVS_WAITREQUEST && AVS_READ && idx == REG_SYNC_CTRL0 && !mode_q[1]
      |-> AVS_READDATA == {24'h0, c0_q & 8'hbb};
  endproperty
  property p_reset_idle;
    $fell(RST) |-> AVS_WAITREQUEST && OUT_HSYNC == '0 && OUT_DE == '0;
  endproperty
  property p_pass;
    !mode_q[0] && !$past(mode_q[0]) && !$past(mode_q[0], 2) && !$past(RST, 2)
      |-> OUT_HSYNC == $past(VID_HSYNC, 2) && OUT_DE == $past(VID_DE, 2);
  endproperty
  property p_blank; mode_q[0] && OUT_HSYNC[0] |-> !OUT_DE[0]; endproperty
  property p_sync_ov;
    mode_q[0] && c0_q[3] && $fell(OUT_HSYNC[0]) |-> run_q == sync_exp;
  endproperty
  a_answer : assert property (p_answer) else $error("no answer");
  a_once : assert property (p_once) else $error("long ack");
  a_cause : assert property (p_cause) else $error("stray ack");
  a_upper : assert property (p_upper) else $error("upper bits");
  a_c0_read : assert property (p_c0_read) else $error("ctrl0");
  a_reset_idle : assert property (p_reset_idle) else $error("reset");
  a_pass : assert property (p_pass) else $error("pass");
  a_blank : assert property (p_blank) else $error("blank");
  a_sync_ov : assert property (p_sync_ov) else $error("sync ov");
  c_read : cover property (!AVS_WAITREQUEST && AVS_READ);
  c_sync_ov : cover property (mode_q[0] && c0_q[3] && $fell(OUT_HSYNC[0]));
  c_pass : cover property (!mode_q[0] && OUT_DE[0]);
endmodule : dihso_props
bind dihso_top dihso_props #(.PORTS(PORTS)) u_props (
  .MCLK(MCLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
  .AVS_WRITE(AVS_WRITE), .AVS_BYTEENABLE(AVS_BYTEENABLE),
  .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .VID_HSYNC(VID_HSYNC),
  .VID_DE(VID_DE), .OUT_HSYNC(OUT_HSYNC), .OUT_DE(OUT_DE));
`default_nettype wire

/* tb_top.sv */
`default_nettype none
module tb_top;
  import dihso_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic              mclk = 1'b0;
  logic              rst = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic              rd = 1'b0;
  logic              wr = 1'b0;
  logic [3:0]        be = 4'h1;
  logic [DATA_W-1:0] wdata = '0;
  logic [DATA_W-1:0] rdata;
  logic              waitreq;
  logic [1:0]        vhs = 2'b00;
  logic [1:0]        vde = 2'b00;
  logic [1:0]        ohs;
  logic [1:0]        ode;
  int                err_count = 0;
  int                checked = 0;
  dihso_top u_dut (.MCLK(mclk), .RST(rst), .AVS_ADDRESS(addr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_BYTEENABLE(be), .AVS_WRITEDATA(wdata),
    .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq), .VID_HSYNC(vhs),
    .VID_DE(vde), .OUT_HSYNC(ohs), .OUT_DE(ode));
  initial forever #2 mclk = ~mclk;
  function automatic logic [7:0] ctrl0_exp(input logic [7:0] v);
    return {v[7], 1'b0, v[5:3], 1'b0, v[1:0]};
  endfunction : ctrl0_exp
  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude
  task automatic bus(input logic w, input logic [7:0] idx,
                     input logic [7:0] d, output logic [7:0] q);
    int n = 0;
    @(posedge mclk);
    addr <= {idx, 2'b00};
    wr <= w;
    rd <= !w;
    wdata <= {24'h0, d};
    do begin
      @(posedge mclk);
      n++;
    end while (waitreq !== 1'b0 && n < 100);
    if (n >= 100) err_count++;
    q = rdata[7:0];
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  task automatic wreg(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, idx, d, q);
  endtask : wreg
  task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] q;
    bus(1'b0, idx, 8'h00, q);
    checked++;
    if (q !== exp) begin
      err_count++;
      $display("CHECK FAILED reg %h expected %h seen %h", idx, exp, q);
    end
  endtask : rchk
  task automatic chk_len(input string nm, input int exp, input int got);
    checked++;
    if (got != exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %0d seen %0d", nm, exp, got);
    end
  endtask : chk_len
  // Long active period keeps input DE high after any regenerated porch.
  task automatic vline(input int s, input int p);
    vhs <= 2'b11;
    repeat (s) @(posedge mclk);
    vhs <= 2'b00;
    repeat (p) @(posedge mclk);
    vde <= 2'b11;
    repeat (400) @(posedge mclk);
    vde <= 2'b00;
    repeat (40) @(posedge mclk);
  endtask : vline
  task automatic meas(input int k, output int hi, output int lo);
    int n = 0;
    hi = 0;
    lo = 0;
    while (ohs[k] !== 1'b1 && n < 400) begin
      @(posedge mclk);
      n++;
    end
    while (ohs[k] === 1'b1 && hi < 400) begin
      @(posedge mclk);
      hi++;
    end
    while (ohs[k] !== 1'b1 && ode[k] !== 1'b1 && lo < 400) begin
      @(posedge mclk);
      lo++;
    end
  endtask : meas
  initial begin
    #80000;
    err_count++;
    $display("Watchdog expired");
    conclude();
  end
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    logic [7:0] v, ia[4], id[4];
    logic [9:0] sv, pv;
    int s, p, h, l, h1, l1;
    void'($urandom(32'hdd3872bd));
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    rchk(REG_SYNC_CTRL0, 8'h00);
    rchk(REG_SYNC_WIDTH_LOW, 8'h00);
    rchk(REG_BACK_PORCH_LOW, 8'h00);
    rchk(8'h00, 8'h00);
    $display("Test reset values done");
    for (int i = 0; i < 8; i++) begin
      v = 8'($urandom);
      wreg(REG_SYNC_CTRL0, v);
      rchk(REG_SYNC_CTRL0, ctrl0_exp(v));
      wreg(REG_SYNC_WIDTH_LOW, ~v);
      rchk(REG_SYNC_WIDTH_LOW, ~v);
      wreg(REG_BACK_PORCH_LOW, v + 8'h01);
      rchk(REG_BACK_PORCH_LOW, v + 8'h01);
    end
    be <= 4'h0;
    wreg(REG_SYNC_WIDTH_LOW, ~v + 8'h01);
    be <= 4'h1;
    rchk(REG_SYNC_WIDTH_LOW, ~v);
    $display("Test override registers done");
    for (int i = 0; i < 4; i++) begin
      ia[i] = 8'(i * 64) + 8'($urandom % 64);
      id[i] = 8'($urandom);
      wreg(REG_PATTERN_INDIRECT_ADDRESS, ia[i]);
      wreg(REG_PATTERN_INDIRECT_DATA, id[i]);
    end
    for (int i = 0; i < 4; i++) begin
      wreg(REG_PATTERN_INDIRECT_ADDRESS, ia[i]);
      rchk(REG_PATTERN_INDIRECT_DATA, id[i]);
    end
    $display("Test indirect access done");
    wreg(REG_MODE, 8'h02);
    for (int k = 0; k < 2; k++) begin
      wreg(REG_PORT_SELECT, 8'(k));
      wreg(REG_PATTERN_INDIRECT_ADDRESS, 8'h10);
      wreg(REG_PATTERN_INDIRECT_DATA, 8'(8'h5a + k));
      wreg(REG_SYNC_CTRL0, 8'(8'h30 + k));
    end
    for (int k = 0; k < 2; k++) begin
      wreg(REG_PORT_SELECT, 8'(k));
      wreg(REG_PATTERN_INDIRECT_ADDRESS, 8'h10);
      rchk(REG_PATTERN_INDIRECT_DATA, 8'(8'h5a + k));
      rchk(REG_SYNC_CTRL0, ctrl0_exp(8'(8'h30 + k)));
    end
    $display("Test independent ports done");
    vline(6, 5);
    wreg(REG_MODE, 8'h01);
    for (int i = 0; i < 4; i++) begin
      s = 3 + $urandom % 10;
      p = 3 + $urandom % 10;
      sv = (i == 3) ? 10'h105 : 10'(13 + $urandom % 30);
      pv = 10'(2 * p);
      wreg(REG_SYNC_WIDTH_LOW, sv[7:0]);
      wreg(REG_BACK_PORCH_LOW, pv[7:0]);
      wreg(REG_SYNC_CTRL0, {i[1], 1'b0, pv[9:8], i[0], 1'b0, sv[9:8]});
      vline(s, p);
      fork
        vline(s, p);
        meas(0, h, l);
        meas(1, h1, l1);
      join
      chk_len("sync width", i[0] ? int'(sv) : s, h);
      chk_len("back porch", i[1] ? int'(pv) : p, l);
      chk_len("sync width 1", i[0] ? int'(sv) : s, h1);
      chk_len("back porch 1", i[1] ? int'(pv) : p, l1);
      rchk(REG_MEASURED_SYNC_LOW, 8'(s));
      rchk(REG_MEASURED_PORCH_LOW, 8'(p));
      rchk(REG_MEASURED_HIGH, 8'h00);
    end
    $display("Test dual-image regeneration done");
    conclude();
  end
endmodule : tb_top
`default_nettype wire
